/* File: rtl/ddcgo_consts.vh */
// Constants for the down-converter gain and over-range detect block.
`ifndef DDCGO_CONSTS_VH
`define DDCGO_CONSTS_VH
`define DDCGO_ADDR_GAIN      12'h210
`define DDCGO_ADDR_THR_I     12'h211
`define DDCGO_ADDR_THR_Q     12'h212
`define DDCGO_ADDR_OVERRANGE_CONFIG   12'h213
`define DDCGO_ADDR_IRQ_STAT  12'h218
`define DDCGO_ADDR_IRQ_EN    12'h219
`define DDCGO_ADDR_IRQ_CLR   12'h21A
`define DDCGO_RST_GAIN       8'h00
`define DDCGO_RST_THR_I      8'hF2
`define DDCGO_RST_THR_Q      8'hAB
`define DDCGO_RST_OVERRANGE_CONFIG    8'h07
`define DDCGO_RST_IRQ_EN     2'h0
`define DDCGO_GAIN_BIT       0
`define DDCGO_PIN_EN_BIT     3
`define DDCGO_EXP_HI         2
`define DDCGO_EXP_LO         0
`define DDCGO_STRETCH_BASE   11'h008
`define DDCGO_THR_SHIFT      7
`endif

/* File: rtl/ddcgo_top.v */
// Down-converter output gain, over-range detection and over-range pin stretching.
// Notes on behaviour
// - Samples pass at unity gain with the gain bit clear and are doubled, saturating at full scale, when it is set.
// - Control bit 0 is set with each I sample whose magnitude reaches the I threshold.
// - Control bit 1 is set with each Q sample whose magnitude reaches the Q threshold.
// - Each 8-bit threshold is a fraction of full scale equal to its value over 256.
// - The pin setup register holds the pin enable at bit 3 and exponent at 2:0, reset 0x07.
// - All four flag pins are low while the pin enable is clear; link bits are unaffected.
// - Each pin pulse lasts at least 8 times two to the exponent clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ddcgo_consts.vh"

module ddcgo_top (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        clkEn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [13:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        sampleValid,
    input  wire [15:0] sampleI,
    input  wire [15:0] sampleQ,
    output reg         outValid,
    output reg  [15:0] outI,
    output reg  [15:0] outQ,
    output reg  [1:0]  linkCtrlBits,
    output reg         channel_a_flag_pin0,
    output reg         channel_a_flag_pin1,
    output reg         channel_b_flag_pin0,
    output reg         channel_b_flag_pin1,
    output reg         irq
);

    reg  [7:0]  gainSetting_q;
    reg  [7:0]  thresholdI_q;
    reg  [7:0]  thresholdQ_q;
    reg  [7:0]  pinSetup_q;
    reg  [1:0]  irqStatus_q;
    reg  [1:0]  irqEnable_q;
    reg  [10:0] stretchCnt_q [0:1];
    reg  [31:0] rdData;
    reg  [1:0]  clrMask;
    wire [1:0]  overFlag;
    wire [15:0] gainI;
    wire [15:0] gainQ;
    wire [11:0] byteAddr;
    wire        busReq;
    wire        wrLane0;
    wire [10:0] stretchLen;

    // Saturating doubling, so a boosted sample clips instead of wrapping.
    function [15:0] boostSample;
        input [15:0] s;
        input        ddc_gain_a;
        begin
            if (!ddc_gain_a) begin
                boostSample = s;
            end else if (s[15] != s[14]) begin
                boostSample = s[15] ? 16'h8000 : 16'h7FFF;
            end else begin
                boostSample = {s[14:0], 1'b0};
            end
        end
    endfunction

    // Magnitude against threshold * full scale / 256; 0x8000 counts as full scale.
    // Full scale is 2^15, so the level is the threshold shifted up by seven bits.
    function overLevel;
        input [15:0] s;
        input [7:0]  thr;
        reg   [16:0] mag;
        begin
            mag = s[15] ? ({1'b0, ~s} + 17'h00001) : {1'b0, s};
            overLevel = (mag >= ({9'h000, thr} << `DDCGO_THR_SHIFT));
        end
    endfunction

    assign gainI = boostSample(sampleI, gainSetting_q[`DDCGO_GAIN_BIT]);
    assign gainQ = boostSample(sampleQ, gainSetting_q[`DDCGO_GAIN_BIT]);
    assign overFlag[0] = sampleValid & overLevel(gainI, thresholdI_q);
    assign overFlag[1] = sampleValid & overLevel(gainQ, thresholdQ_q);
    assign byteAddr = wb_adr_i[13:2];
    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrLane0 = busReq & wb_we_i & wb_sel_i[0];
    assign stretchLen = `DDCGO_STRETCH_BASE << pinSetup_q[`DDCGO_EXP_HI:`DDCGO_EXP_LO];

    always @* begin
        rdData = 32'h00000000;
        clrMask = 2'h0;
        case (byteAddr)
            `DDCGO_ADDR_GAIN: begin
                rdData[7:0] = gainSetting_q;
            end
            `DDCGO_ADDR_THR_I: begin
                rdData[7:0] = thresholdI_q;
            end
            `DDCGO_ADDR_THR_Q: begin
                rdData[7:0] = thresholdQ_q;
            end
            `DDCGO_ADDR_OVERRANGE_CONFIG: begin
                rdData[7:0] = pinSetup_q;
            end
            `DDCGO_ADDR_IRQ_STAT: begin
                rdData[1:0] = irqStatus_q;
            end
            `DDCGO_ADDR_IRQ_EN: begin
                rdData[1:0] = irqEnable_q;
            end
            `DDCGO_ADDR_IRQ_CLR: begin
                clrMask = wrLane0 ? wb_dat_i[1:0] : 2'h0;
            end
            default: begin
                rdData = 32'h00000000;
            end
        endcase
    end

    // Register bus: one wait-free answer per request, unmapped reads give zero.
    always @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h00000000;
            gainSetting_q <= `DDCGO_RST_GAIN;
            thresholdI_q  <= `DDCGO_RST_THR_I;
            thresholdQ_q  <= `DDCGO_RST_THR_Q;
            pinSetup_q    <= `DDCGO_RST_OVERRANGE_CONFIG;
            irqEnable_q   <= `DDCGO_RST_IRQ_EN;
            irqStatus_q   <= 2'h0;
            irq           <= 1'b0;
        end else if (clkEn) begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? rdData : 32'h00000000;
            if (wrLane0) begin
                case (byteAddr)
                    `DDCGO_ADDR_GAIN: begin
                        gainSetting_q <= wb_dat_i[7:0];
                    end
                    `DDCGO_ADDR_THR_I: begin
                        thresholdI_q <= wb_dat_i[7:0];
                    end
                    `DDCGO_ADDR_THR_Q: begin
                        thresholdQ_q <= wb_dat_i[7:0];
                    end
                    `DDCGO_ADDR_OVERRANGE_CONFIG: begin
                        pinSetup_q <= wb_dat_i[7:0];
                    end
                    `DDCGO_ADDR_IRQ_EN: begin
                        irqEnable_q <= wb_dat_i[1:0];
                    end
                    default: begin
                        irqEnable_q <= irqEnable_q;
                    end
                endcase
            end
            // A detection in the clearing cycle wins over the clear.
            irqStatus_q <= (irqStatus_q & ~clrMask) | overFlag;
            irq <= |(((irqStatus_q & ~clrMask) | overFlag) & irqEnable_q);
        end
    end

    // Sample path: gained samples with their over-range control bits, one cycle late.
    always @(posedge sys_clk) begin
        if (rst) begin
            outValid     <= 1'b0;
            outI         <= 16'h0000;
            outQ         <= 16'h0000;
            linkCtrlBits <= 2'h0;
        end else if (clkEn) begin
            outValid     <= sampleValid;
            outI         <= gainI;
            outQ         <= gainQ;
            linkCtrlBits <= overFlag;
        end
    end

    // Each channel holds its pin pair high for the stretch length after the last hit.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gStretch
            always @(posedge sys_clk) begin
                if (rst) begin
                    stretchCnt_q[ch] <= 11'h000;
                end else if (clkEn) begin
                    if (overFlag[ch]) begin
                        stretchCnt_q[ch] <= stretchLen;
                    end else if (stretchCnt_q[ch] != 11'h000) begin
                        stretchCnt_q[ch] <= stretchCnt_q[ch] - 11'h001;
                    end
                end
            end
        end
    endgenerate

    // Channel A pins follow the I detector and channel B pins the Q detector.
    always @(posedge sys_clk) begin
        if (rst) begin
            channel_a_flag_pin0 <= 1'b0;
            channel_a_flag_pin1 <= 1'b0;
            channel_b_flag_pin0 <= 1'b0;
            channel_b_flag_pin1 <= 1'b0;
        end else if (clkEn) begin
            channel_a_flag_pin0 <= pinSetup_q[`DDCGO_PIN_EN_BIT]
                                   & (overFlag[0] | (stretchCnt_q[0] > 11'h001));
            channel_a_flag_pin1 <= pinSetup_q[`DDCGO_PIN_EN_BIT]
                                   & (overFlag[0] | (stretchCnt_q[0] > 11'h001));
            channel_b_flag_pin0 <= pinSetup_q[`DDCGO_PIN_EN_BIT]
                                   & (overFlag[1] | (stretchCnt_q[1] > 11'h001));
            channel_b_flag_pin1 <= pinSetup_q[`DDCGO_PIN_EN_BIT]
                                   & (overFlag[1] | (stretchCnt_q[1] > 11'h001));
        end
    end

endmodule // ddcgo_top
`default_nettype wire

/* File: tb/ddcgo_checker.sv */
// Port-level checks for the gain and over-range block.
`timescale 1ns/1ps
`default_nettype none
module ddcgo_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        sampleValid,
    input wire logic [15:0] sampleI,
    input wire logic [15:0] sampleQ,
    input wire logic [15:0] outI,
    input wire logic [1:0]  linkCtrlBits,
    input wire logic        channel_a_flag_pin0
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || !clkEn);
    property p_gain; sampleValid && sampleI[15:13] == 3'h0 |=> outI == $past(sampleI) || outI == $past(sampleI) << 1; endproperty
    a_gain: assert property (p_gain) else $error("gain wrong");
    property p_hitI; sampleValid && sampleI == 16'h7FFF |=> linkCtrlBits[0]; endproperty
    a_hitI: assert property (p_hitI) else $error("I flag missing");
    property p_hitQ; sampleValid && sampleQ == 16'h8000 |=> linkCtrlBits[1]; endproperty
    a_hitQ: assert property (p_hitQ) else $error("Q flag missing");
    property p_quiet; sampleValid && sampleI == 16'h0 && sampleQ == 16'h0 |=> linkCtrlBits == 2'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("flag on zero");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_cause; $rose(channel_a_flag_pin0) |-> linkCtrlBits[0]; endproperty
    a_cause: assert property (p_cause) else $error("pin without hit");
    property p_stretch; $rose(channel_a_flag_pin0) |=> channel_a_flag_pin0 [*7]; endproperty
    a_stretch: assert property (p_stretch) else $error("pulse short");
    c_both: cover property (linkCtrlBits == 2'h3);
    c_pin: cover property ($rose(channel_a_flag_pin0));
    c_ack: cover property (wb_ack_o);
endmodule // ddcgo_checker
`default_nettype wire

/* File: tb/ddcgo_sink.sv */
// Far-side model: measures each over-range pin pulse in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module ddcgo_sink (
    input  wire logic sys_clk,
    input  wire logic flagPin,
    output var  int   lastLen
);
    int runLen = 0;
    always @(posedge sys_clk) begin
        runLen <= flagPin ? runLen + 1 : 0;
        if (!flagPin && runLen != 0) lastLen <= runLen;
    end
endmodule // ddcgo_sink
`default_nettype wire

/* File: tb/ddcgo_top_tb.sv */
// Self-checking bench for the gain and over-range block.
`timescale 1ns/1ps
`default_nettype none
module ddcgo_top_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, rd;
    logic        sVal = 1'b0;
    logic [15:0] sI = 16'h0, sQ = 16'h0;
    wire  [31:0] rdat;
    wire  [15:0] oI;
    wire  [1:0]  lnk;
    wire         ack, pa0, irq;
    int          n_fail = 0, n_compared = 0, cycles = 0, plen;
    logic [31:0] rv [5] = '{32'h0, 32'hF2, 32'hAB, 32'h07, 32'h0};
    int          nx [2] = '{0, 2};
    ddcgo_top dut (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i({adr, 2'h0}), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sampleValid(sVal), .sampleI(sI), .sampleQ(sQ), .outValid(), .outI(oI),
        .outQ(), .linkCtrlBits(lnk), .channel_a_flag_pin0(pa0), .channel_a_flag_pin1(),
        .channel_b_flag_pin0(), .channel_b_flag_pin1(), .irq(irq));
    ddcgo_sink sink (.sys_clk(sys_clk), .flagPin(pa0), .lastLen(plen));
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge sys_clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
    endtask
    task automatic smp(input logic [15:0] i, input logic [15:0] q);
        @(posedge sys_clk);
        sVal <= 1'b1;
        sI <= i;
        sQ <= q;
        @(posedge sys_clk);
        sVal <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // The limit is far above the fewer than 200 cycles the tests need.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rv[k]) begin
            bus(1'b0, 12'h210 + 12'(k), 32'h0);
            cmp(rd, rv[k]);
        end
        $display("reset values done");
        bus(1'b1, 12'h213, 32'h0);
        smp(16'h1000, 16'h0);
        cmp(oI, 16'h1000);
        bus(1'b1, 12'h210, 32'h1);
        smp(16'h1000, 16'h0);
        cmp(oI, 16'h2000);
        smp(16'h7000, 16'h0);
        cmp(oI, 16'h7FFF);
        bus(1'b1, 12'h210, 32'h0);
        $display("gain done");
        bus(1'b1, 12'h211, 32'h40);
        bus(1'b1, 12'h212, 32'h80);
        smp(16'h2000, 16'h3FFF);
        cmp(lnk, 2'h1);
        cmp(pa0, 1'b0);
        smp(16'h1FFF, 16'hC000);
        cmp(lnk, 2'h2);
        smp(16'hE000, 16'hC001);
        cmp(lnk, 2'h1);
        $display("thresholds done");
        // Let the short stretch from the hits above run out before the pins are enabled.
        repeat (12) @(posedge sys_clk);
        foreach (nx[k]) begin
            bus(1'b1, 12'h213, 32'h8 | nx[k]);
            bus(1'b0, 12'h213, 32'h0);
            cmp(rd, 32'h8 | nx[k]);
            smp(16'h7FFF, 16'h0);
            repeat ((8 << nx[k]) + 4) @(posedge sys_clk);
            cmp(plen, 8 << nx[k]);
        end
        $display("pins done");
        cmp(irq, 1'b0);
        bus(1'b1, 12'h219, 32'h3);
        bus(1'b0, 12'h218, 32'h0);
        cmp(rd, 32'h3);
        cmp(irq, 1'b1);
        bus(1'b1, 12'h21A, 32'h3);
        bus(1'b0, 12'h218, 32'h0);
        cmp(irq, 1'b0);
        $display("interrupt done");
        report_and_stop();
    end
endmodule // ddcgo_top_tb
bind ddcgo_top ddcgo_checker chk (.*);
`default_nettype wire
